// File: core/deep_sleep_pkg.sv
package deep_sleep_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int LEN_W  = 32;
  localparam int LEAD_W = 10;

  // ********************************************************************
  // Slot timing reference
  // ********************************************************************
  localparam int unsigned SLOT_US     = 625;
  localparam int unsigned US_PER_S    = 1000000;
  localparam int unsigned LP_CLK_HZ   = 32768;

  // ********************************************************************
  // Register map of the controller (byte addresses, word aligned)
  // ********************************************************************
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_LENGTH = 5'h04;
  localparam logic [4:0] OFS_TIMING = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;
  localparam logic [4:0] OFS_LAST   = 5'h10;

  // Control register fields
  localparam int CTRL_SLEEP_ON  = 0;
  localparam int CTRL_WAKE_REQ  = 1;
  localparam int CTRL_EXT_DIS   = 2;
  localparam int CTRL_CLK_EN    = 3;
  localparam int CTRL_RADIO_ON  = 4;
  localparam int CTRL_WAIT_TRIM = 5;

  // Timing register fields
  localparam int TIM_SET_LSB = 0;
  localparam int TIM_CLR_LSB = 10;
  localparam int TIM_EXT_LSB = 20;

  // Status register fields
  localparam int STAT_EARLY_LVL  = 0;
  localparam int STAT_EARLY_SEEN = 1;
  localparam int STAT_EXIT_SEEN  = 2;
  localparam int STAT_ASLEEP     = 3;
  localparam int STAT_SETTLED    = 4;
  localparam int STAT_TRIM_DONE  = 5;

  // Reset values
  localparam logic [LEAD_W-1:0] RST_SET_LEAD = 10'h020;
  localparam logic [LEAD_W-1:0] RST_CLR_LEAD = 10'h002;
  localparam logic [LEAD_W-1:0] RST_EXT_LEN  = 10'h003;
  localparam logic [LEN_W-1:0]  RST_LENGTH   = 32'h0000_0100;

endpackage

// File: core/sleep_link_if.sv
`timescale 1ns/1ps
interface sleep_link_if;
  import deep_sleep_pkg::*;

  // Controller to sequencer
  logic              deep_sleep_on;
  logic [LEN_W-1:0]  programmed_sleep_length;
  logic [LEAD_W-1:0] wake_irq_set_lead;
  logic [LEAD_W-1:0] wake_irq_clear_lead;
  logic [LEAD_W-1:0] ext_wake_pulse_len;
  logic              ext_wake_disable;
  logic              soft_wake_request;
  logic              core_clk_en;
  logic              radio_domain_up;

  // Sequencer to controller
  logic              early_wake_irq;
  logic              sleep_exit_irq;
  logic              asleep;
  logic [LEN_W-1:0]  last_sleep_length;

  modport dev (
    input  deep_sleep_on, programmed_sleep_length, wake_irq_set_lead,
           wake_irq_clear_lead, ext_wake_pulse_len, ext_wake_disable,
           soft_wake_request, core_clk_en, radio_domain_up,
    output early_wake_irq, sleep_exit_irq, asleep, last_sleep_length
  );

  modport host (
    output deep_sleep_on, programmed_sleep_length, wake_irq_set_lead,
           wake_irq_clear_lead, ext_wake_pulse_len, ext_wake_disable,
           soft_wake_request, core_clk_en, radio_domain_up,
    input  early_wake_irq, sleep_exit_irq, asleep, last_sleep_length
  );
endinterface

// File: core/sleep_wake_seq.sv
// Behaviour
// R1 - Leave sleep by timer expiry or wake request
// R2 - Early wake interrupt precedes scheduled wake time
// R3 - Software enables clocks and radio before resume
// R4 - Stay asleep after expiry until powered up
// R5 - Record actual length of last sleep
// R6 - Exit and interrupt only when expired, clocked, powered; a wake request exits without expiry
// R7 - Wake request raises early interrupt at once
// R8 - External wake pulse length sets interrupt width
// R9 - Recommend pulse length as clear lead plus one
// R10 - No sleep entry while wake request high
// R11 - Disable bit masks the wake request event
// R12 - Software may delay request until trim done
// R13 - Software waits for crystal settled first
// R14 - Set lead: ticks before expiry to assert
// R15 - Clear lead: ticks before expiry to deassert
// R16 - Sleep length at least set lead plus one
// R17 - Keep 625 us slot reference during sleep
// R18 - Sample request and power-up on low-power ticks
`timescale 1ns/1ps
module sleep_wake_seq #(
  parameter int unsigned LP_HZ = deep_sleep_pkg::LP_CLK_HZ
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // Low-power clock pin and slot reference
  input  wire logic low_power_clock,
  output logic      slot_tick,
  // Link to the controller
  sleep_link_if.dev link
);
  import deep_sleep_pkg::*;

  // ********************************************************************
  // Low-power clock sampling
  // ********************************************************************
  logic lpc_s1_ff;
  logic lpc_s2_ff;
  logic lpc_s3_ff;
  logic lp_tick;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lpc_s1_ff <= 1'b0;
      lpc_s2_ff <= 1'b0;
      lpc_s3_ff <= 1'b0;
    end else begin
      lpc_s1_ff <= low_power_clock;
      lpc_s2_ff <= lpc_s1_ff;
      lpc_s3_ff <= lpc_s2_ff;
    end
  end

  assign lp_tick = lpc_s2_ff & ~lpc_s3_ff;

  // ********************************************************************
  // Slot reference on the low-power clock
  // ********************************************************************
  // A fractional accumulator keeps the average slot at exactly 625 us even
  // though the low-power period does not divide it.
  localparam logic [LEN_W-1:0] SLOT_STEP  = LEN_W'(US_PER_S);
  localparam logic [LEN_W-1:0] SLOT_WRAP  = LEN_W'(LP_HZ * SLOT_US);
  logic [LEN_W-1:0] slot_acc_ff;
  logic [LEN_W-1:0] nxt_slot_acc;

  assign nxt_slot_acc = slot_acc_ff + SLOT_STEP;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slot_acc_ff <= '0;
      slot_tick   <= 1'b0;
    end else begin
      slot_tick <= 1'b0;
      if (lp_tick) begin
        if (nxt_slot_acc >= SLOT_WRAP) begin // R17
          slot_acc_ff <= nxt_slot_acc - SLOT_WRAP;
          slot_tick   <= 1'b1;
        end else begin
          slot_acc_ff <= nxt_slot_acc;
        end
      end
    end
  end

  // ********************************************************************
  // Inputs sampled on low-power ticks, and the request on every mclk edge
  // ********************************************************************
  logic wake_lp_ff;
  logic wake_lp_prev_ff;
  logic up_lp_ff;
  logic req_prev_ff;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wake_lp_ff      <= 1'b0;
      wake_lp_prev_ff <= 1'b0;
      up_lp_ff        <= 1'b0;
    end else if (lp_tick) begin
      wake_lp_ff      <= link.soft_wake_request; // R18
      wake_lp_prev_ff <= wake_lp_ff;
      up_lp_ff        <= link.core_clk_en & link.radio_domain_up; // R18
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      req_prev_ff <= 1'b0;
    end else begin
      req_prev_ff <= link.soft_wake_request;
    end
  end

  // ********************************************************************
  // Sleep sequencer
  // ********************************************************************
  typedef enum logic [1:0] {st_active, st_sleep, st_ext_wake, st_wait_up} seq_state_t;

  seq_state_t        state_ff;
  logic [LEN_W-1:0]  length_ff;
  logic [LEN_W-1:0]  elapsed_ff;
  logic [LEN_W-1:0]  nxt_elapsed;
  logic [LEN_W-1:0]  remain_nxt;
  logic [LEAD_W-1:0] ext_cnt_ff;
  logic [LEAD_W-1:0] nxt_ext_cnt;
  logic [LEAD_W-1:0] ext_hold;
  logic              req_rise;
  logic              wake_event;
  logic              enter_ok;
  logic              expire;
  logic              ext_done;
  logic              exit_now;

  assign nxt_elapsed = elapsed_ff + LEN_W'(1);
  assign remain_nxt  = length_ff - nxt_elapsed;
  assign nxt_ext_cnt = ext_cnt_ff + LEAD_W'(1);

  // The pulse lasts the pulse length minus the clear lead, never under one tick
  always_comb begin
    if (link.ext_wake_pulse_len > link.wake_irq_clear_lead) begin
      ext_hold = link.ext_wake_pulse_len - link.wake_irq_clear_lead; // R8
    end else begin
      ext_hold = LEAD_W'(1);
    end
  end

  assign enter_ok   = link.deep_sleep_on & ~link.soft_wake_request; // R10
  assign req_rise   = link.soft_wake_request & ~req_prev_ff & ~link.ext_wake_disable
                    & (state_ff == st_sleep); // R11
  assign wake_event = lp_tick & wake_lp_ff & ~wake_lp_prev_ff & ~link.ext_wake_disable;
  assign expire     = lp_tick & (nxt_elapsed >= length_ff);
  assign ext_done   = lp_tick & (nxt_ext_cnt >= ext_hold);
  assign exit_now   = lp_tick & up_lp_ff & (state_ff == st_wait_up); // R6

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= st_active;
    end else begin
      case (state_ff)
        st_active: begin
          if (enter_ok) begin
            state_ff <= st_sleep;
          end
        end
        st_sleep: begin
          if (wake_event || req_rise) begin // R1
            state_ff <= st_ext_wake;
          end else if (expire) begin // R1
            state_ff <= st_wait_up;
          end
        end
        st_ext_wake: begin
          if (ext_done) begin
            state_ff <= st_wait_up;
          end
        end
        st_wait_up: begin
          if (exit_now) begin // R4
            state_ff <= st_active;
          end
        end
        default: state_ff <= st_active;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      length_ff <= RST_LENGTH;
    end else if (state_ff == st_active && enter_ok) begin
      length_ff <= link.programmed_sleep_length;
    end
  end

  // Elapsed ticks keep counting past expiry, so late power-up shows
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      elapsed_ff <= '0;
    end else if (state_ff == st_active) begin
      elapsed_ff <= '0;
    end else if (lp_tick) begin
      elapsed_ff <= nxt_elapsed; // R5
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_cnt_ff <= '0;
    end else if (state_ff != st_ext_wake) begin
      ext_cnt_ff <= '0;
    end else if (lp_tick) begin
      ext_cnt_ff <= nxt_ext_cnt;
    end
  end

  // ********************************************************************
  // Early wake interrupt
  // ********************************************************************
  logic early_set;
  logic early_clr;

  assign early_set = req_rise // R7
                   | (state_ff == st_sleep & lp_tick & ~wake_event
                      & remain_nxt == LEN_W'(link.wake_irq_set_lead)) // R2 R14
                   | (state_ff == st_active & enter_ok
                      & link.programmed_sleep_length <= LEN_W'(link.wake_irq_set_lead));
  assign early_clr = (state_ff == st_sleep & lp_tick & ~wake_event
                      & remain_nxt == LEN_W'(link.wake_irq_clear_lead)) // R15
                   | (state_ff == st_ext_wake & ext_done) // R8
                   | exit_now;

  // Set wins over clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link.early_wake_irq <= 1'b0;
    end else if (early_set) begin
      link.early_wake_irq <= 1'b1;
    end else if (early_clr) begin
      link.early_wake_irq <= 1'b0;
    end
  end

  // ********************************************************************
  // Exit report
  // ********************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link.sleep_exit_irq    <= 1'b0;
      link.last_sleep_length <= '0;
      link.asleep            <= 1'b0;
    end else begin
      link.sleep_exit_irq <= exit_now; // R6
      link.asleep         <= (state_ff != st_active) | enter_ok;
      if (exit_now) begin
        link.last_sleep_length <= nxt_elapsed; // R5
      end
    end
  end

endmodule

// File: core/sleep_ctrl_host.sv
`timescale 1ns/1ps
module sleep_ctrl_host (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  // Avalon-MM slave
  input  wire logic [4:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // Crystal status pins
  input  wire logic                   fast_xtal_settled,
  input  wire logic                   fast_xtal_trim_done,
  // Link to the sequencer
  sleep_link_if.host                  link
);
  import deep_sleep_pkg::*;

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic settled_s1_ff;
  logic settled_ff;
  logic trim_s1_ff;
  logic trim_ff;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      settled_s1_ff <= 1'b0;
      settled_ff    <= 1'b0;
      trim_s1_ff    <= 1'b0;
      trim_ff       <= 1'b0;
    end else begin
      settled_s1_ff <= fast_xtal_settled;
      settled_ff    <= settled_s1_ff;
      trim_s1_ff    <= fast_xtal_trim_done;
      trim_ff       <= trim_s1_ff;
    end
  end

  // ********************************************************************
  // Bus handshake: every access completes on its second cycle
  // ********************************************************************
  logic req;
  logic done_ff;
  logic take;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~done_ff;
  assign take            = req & done_ff;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= req & ~done_ff;
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [5:0]        ctrl_ff;
  logic [LEN_W-1:0]  length_ff;
  logic [LEAD_W-1:0] set_lead_ff;
  logic [LEAD_W-1:0] clr_lead_ff;
  logic [LEAD_W-1:0] ext_len_ff;
  logic              sleep_on_ff;
  logic              early_seen_ff;
  logic              exit_seen_ff;
  logic              wr_ctrl;
  logic              wr_length;
  logic              wr_timing;
  logic              wr_status;
  logic [LEN_W-1:0]  min_len;
  logic [LEAD_W-1:0] wr_set_lead;

  assign wr_ctrl     = take & avs_write & (avs_address == OFS_CTRL);
  assign wr_length   = take & avs_write & (avs_address == OFS_LENGTH);
  assign wr_timing   = take & avs_write & (avs_address == OFS_TIMING);
  assign wr_status   = take & avs_write & (avs_address == OFS_STATUS);
  assign wr_set_lead = avs_writedata[TIM_SET_LSB +: LEAD_W];
  assign min_len     = LEN_W'(set_lead_ff) + LEN_W'(1);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff     <= '0;
      sleep_on_ff <= 1'b0;
    end else begin
      sleep_on_ff <= wr_ctrl & avs_writedata[CTRL_SLEEP_ON];
      if (wr_ctrl) begin
        ctrl_ff <= {avs_writedata[5:1], 1'b0};
      end
    end
  end

  // Too short a length would fire the early interrupt before software waits
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      length_ff <= RST_LENGTH;
    end else if (wr_length) begin
      length_ff <= (avs_writedata < min_len) ? min_len : avs_writedata; // R16
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      set_lead_ff <= RST_SET_LEAD;
      clr_lead_ff <= RST_CLR_LEAD;
      ext_len_ff  <= RST_EXT_LEN; // R9
    end else if (wr_timing) begin
      set_lead_ff <= wr_set_lead;
      clr_lead_ff <= avs_writedata[TIM_CLR_LSB +: LEAD_W];
      ext_len_ff  <= avs_writedata[TIM_EXT_LSB +: LEAD_W];
    end
  end

  // Sticky flags: a new event in the clearing cycle wins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      early_seen_ff <= 1'b0;
      exit_seen_ff  <= 1'b0;
    end else begin
      if (link.early_wake_irq) begin
        early_seen_ff <= 1'b1;
      end else if (wr_status && avs_writedata[STAT_EARLY_SEEN]) begin
        early_seen_ff <= 1'b0;
      end
      if (link.sleep_exit_irq) begin
        exit_seen_ff <= 1'b1;
      end else if (wr_status && avs_writedata[STAT_EXIT_SEEN]) begin
        exit_seen_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= '0;
    end else if (req && !done_ff) begin
      case (avs_address)
        OFS_CTRL:   avs_readdata <= {26'h0, ctrl_ff};
        OFS_LENGTH: avs_readdata <= length_ff;
        OFS_TIMING: avs_readdata <= {2'h0, ext_len_ff, clr_lead_ff, set_lead_ff};
        OFS_STATUS: avs_readdata <= {26'h0, trim_ff, settled_ff, link.asleep,
                                     exit_seen_ff, early_seen_ff, link.early_wake_irq};
        OFS_LAST:   avs_readdata <= link.last_sleep_length;
        default:    avs_readdata <= '0;
      endcase
    end
  end

  // ********************************************************************
  // Drive the sequencer
  // ********************************************************************
  assign link.deep_sleep_on           = sleep_on_ff;
  assign link.programmed_sleep_length = length_ff;
  assign link.wake_irq_set_lead       = set_lead_ff;
  assign link.wake_irq_clear_lead     = clr_lead_ff;
  assign link.ext_wake_pulse_len      = ext_len_ff;
  assign link.ext_wake_disable        = ctrl_ff[CTRL_EXT_DIS];
  assign link.soft_wake_request       = ctrl_ff[CTRL_WAKE_REQ]
                                      & (~ctrl_ff[CTRL_WAIT_TRIM] | trim_ff); // R12
  assign link.core_clk_en             = ctrl_ff[CTRL_CLK_EN] & settled_ff; // R3 R13
  assign link.radio_domain_up         = ctrl_ff[CTRL_RADIO_ON] & settled_ff; // R3

endmodule

// File: sim/sleep_link_props.sv
`timescale 1ns/1ps
module sleep_link_props (
  // Clock and reset
  input wire logic                             mclk,
  input wire logic                             reset_n,
  // Controller to sequencer
  input wire logic                             deep_sleep_on,
  input wire logic                             ext_wake_disable,
  input wire logic                             soft_wake_request,
  input wire logic                             core_clk_en,
  input wire logic                             radio_domain_up,
  // Sequencer to controller
  input wire logic                             early_wake_irq,
  input wire logic                             sleep_exit_irq,
  input wire logic                             asleep,
  input wire logic [deep_sleep_pkg::LEN_W-1:0] last_sleep_length
);
  import deep_sleep_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ******************************************************************
  // Steps of entry and exit
  // ******************************************************************
  sequence s_entry_req;
    deep_sleep_on && !asleep;
  endsequence

  sequence s_clean_exit;
    ##1 (!asleep && !early_wake_irq && !sleep_exit_irq);
  endsequence

  // ******************************************************************
  // Checks
  // ******************************************************************
  a_exit_needs_power: assert property (sleep_exit_irq |-> core_clk_en && radio_domain_up)
    else $error("sleep exit without clocks and radio");
  a_exit_clean: assert property (sleep_exit_irq |-> s_clean_exit)
    else $error("exit pulse not followed by awake state");
  a_exit_from_sleep: assert property (sleep_exit_irq |-> $past(asleep))
    else $error("exit pulse while not asleep");
  a_entry_refused: assert property (s_entry_req ##0 soft_wake_request |=> !asleep)
    else $error("sleep entered while wake request high");
  a_entry_taken: assert property (s_entry_req ##0 !soft_wake_request |=> asleep)
    else $error("sleep request not taken");
  a_wake_early: assert property ($rose(soft_wake_request) && asleep && !ext_wake_disable
    |=> early_wake_irq)
    else $error("wake request did not raise early interrupt");
  a_last_on_exit: assert property ($changed(last_sleep_length) |-> sleep_exit_irq)
    else $error("sleep length changed outside exit");
  a_early_awake_low: assert property (!asleep && !$past(asleep) |-> !early_wake_irq)
    else $error("early interrupt while awake");
  a_sleep_cause: assert property ($rose(asleep) |-> $past(deep_sleep_on))
    else $error("sleep entered without request");
endmodule

// File: sim/test_link_core_deep_sleep_wake.sv
`timescale 1ns/1ps
module test_link_core_deep_sleep_wake;
  import deep_sleep_pkg::*;

  logic             mclk;
  logic             reset_n;
  logic             low_power_clock = 1'b0;
  logic [3:0]       lp_div = 4'h0;
  logic [4:0]       avs_address;
  logic             avs_read;
  logic             avs_write;
  logic [31:0]      avs_writedata;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic             fast_xtal_settled;
  logic             fast_xtal_trim_done;
  logic             slot_tick;
  logic [31:0]      rdata;
  logic [LEN_W-1:0] last_len;
  int               err_total;
  int               checks_done;
  int               slot_cnt = 0;
  int               n;
  longint           exp_slots;

  sleep_link_if sleep_link_if_inst ();
  assign last_len = sleep_link_if_inst.last_sleep_length;

  sleep_wake_seq #(.LP_HZ(LP_CLK_HZ)) sleep_wake_seq_inst (.mclk(mclk), .reset_n(reset_n),
    .low_power_clock(low_power_clock), .slot_tick(slot_tick), .link(sleep_link_if_inst));
  sleep_ctrl_host sleep_ctrl_host_inst (.mclk(mclk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fast_xtal_settled(fast_xtal_settled),
    .fast_xtal_trim_done(fast_xtal_trim_done), .link(sleep_link_if_inst));
  sleep_link_props sleep_link_props_inst (.mclk(mclk), .reset_n(reset_n),
    .deep_sleep_on(sleep_link_if_inst.deep_sleep_on),
    .ext_wake_disable(sleep_link_if_inst.ext_wake_disable),
    .soft_wake_request(sleep_link_if_inst.soft_wake_request),
    .core_clk_en(sleep_link_if_inst.core_clk_en),
    .radio_domain_up(sleep_link_if_inst.radio_domain_up),
    .early_wake_irq(sleep_link_if_inst.early_wake_irq),
    .sleep_exit_irq(sleep_link_if_inst.sleep_exit_irq),
    .asleep(sleep_link_if_inst.asleep), .last_sleep_length(last_len));

  // ******************************************************************
  // Clocks: low-power pin runs free at 1/16 of mclk, slow enough for its sync
  // ******************************************************************
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    lp_div <= lp_div + 4'h1;
    low_power_clock <= lp_div[3];
    if (slot_tick === 1'b1) slot_cnt <= slot_cnt + 1;
  end

  // ******************************************************************
  // Helpers
  // ******************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic lost();
    chk(32'h0, 32'h1);
    summarize();
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  // Avalon request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge mclk);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) lost();
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  function automatic logic sig(input int sel);
    case (sel)
      0: return sleep_link_if_inst.early_wake_irq;
      1: return sleep_link_if_inst.sleep_exit_irq;
      default: return sleep_link_if_inst.asleep;
    endcase
  endfunction

  task automatic wait_for(input int sel, input int lim);
    int k;
    k = 0;
    #1;
    while (sig(sel) !== 1'b1) begin
      if (k == lim) lost();
      tick(1);
      k++;
    end
  endtask

  task automatic count_high(input int sel, input int lim);
    n = 0;
    while (sig(sel) === 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  task automatic end_test(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, err_total);
  endtask

  // ******************************************************************
  // Sequence of tests
  // ******************************************************************
  initial begin
    err_total = 0;
    checks_done = 0;
    reset_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    fast_xtal_settled = 1'b0;
    fast_xtal_trim_done = 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    bus(1'b0, OFS_TIMING, 32'h0);
    chk(rdata, {2'h0, RST_EXT_LEN, RST_CLR_LEAD, RST_SET_LEAD});
    bus(1'b0, OFS_LENGTH, 32'h0);
    chk(rdata, RST_LENGTH);
    bus(1'b0, 5'h06, 32'h0);
    chk(rdata, 32'h0);
    end_test("reset");
    // Timer expiry while clocks and radio are still off
    bus(1'b1, OFS_TIMING, 32'h0030_0808);
    bus(1'b1, OFS_LENGTH, 32'h0000_0001);
    bus(1'b0, OFS_LENGTH, 32'h0);
    chk(rdata, 32'h0000_0009);
    bus(1'b1, OFS_LENGTH, 32'h0000_0014);
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    wait_for(0, 1000);
    count_high(0, 500);
    chk(32'(n), 32'((8 - 2) * 16));
    tick(400);
    chk(32'(sig(2)), 32'h1);
    @(posedge mclk);
    fast_xtal_settled <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h0000_0018);
    wait_for(1, 1000);
    chk(32'(last_len > 32'h14), 32'h1);
    end_test("late power-up");
    // Powered before expiry
    bus(1'b1, OFS_CTRL, 32'h0000_0019);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rdata, 32'h0000_0018);
    wait_for(1, 1000);
    chk(32'(last_len >= 32'h14 && last_len <= 32'h15), 32'h1);
    bus(1'b0, OFS_LAST, 32'h0);
    chk(32'(rdata >= 32'h14 && rdata <= 32'h15), 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rdata, 32'h0000_0016);
    bus(1'b1, OFS_STATUS, 32'h0000_0006);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(rdata, 32'h0000_0010);
    end_test("prompt power-up");
    // Software wake request during a long sleep
    bus(1'b1, OFS_LENGTH, 32'h0000_00c8);
    bus(1'b1, OFS_CTRL, 32'h0000_0019);
    wait_for(2, 20);
    tick(50);
    bus(1'b1, OFS_CTRL, 32'h0000_003a);
    tick(32);
    chk(32'(sig(0)), 32'h0);
    @(posedge mclk);
    fast_xtal_trim_done <= 1'b1;
    wait_for(0, 8);
    count_high(0, 100);
    chk(32'(n >= 1 && n <= 32), 32'h1);
    wait_for(1, 200);
    chk(32'(last_len < 32'hc8), 32'h1);
    bus(1'b1, OFS_CTRL, 32'h0000_001b);
    tick(8);
    chk(32'(sig(2)), 32'h0);
    end_test("wake request");
    // Wake request masked by the disable bit
    bus(1'b1, OFS_CTRL, 32'h0000_001c);
    bus(1'b1, OFS_CTRL, 32'h0000_001d);
    wait_for(2, 20);
    bus(1'b1, OFS_CTRL, 32'h0000_001e);
    n = 0;
    repeat (32) begin
      tick(1);
      n += 32'(sig(0));
    end
    chk(32'(n), 32'h0);
    wait_for(1, 5000);
    chk(32'(last_len >= 32'hc8), 32'h1);
    end_test("wake disabled");
    // Slot reference over 1024 low-power periods
    exp_slots = (64'd1024 * US_PER_S) / (64'(SLOT_US) * LP_CLK_HZ);
    n = slot_cnt;
    tick(16 * 1024);
    n = slot_cnt - n;
    chk(32'(n >= exp_slots - 1 && n <= exp_slots + 1), 32'h1);
    end_test("slot reference");
    summarize();
  end
endmodule
